// *** hdl/tlb_inrush.sv ***
// second harmonic inrush detector with reset hold timer
module tlb_inrush
  import tlb_pkg::*;
#(
  parameter int STEP_CYCLES = TLB_STEP_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   enable_i,
  input  wire logic [TLB_RATIO_W-1:0] threshold_i,
  input  wire logic [7:0]             treset_i,
  input  wire logic [TLB_RATIO_W-1:0] ratio_a_i,
  input  wire logic [TLB_RATIO_W-1:0] ratio_b_i,
  input  wire logic [TLB_RATIO_W-1:0] ratio_c_i,
  output logic                        inrush_o
);
  logic [31:0] step_q;
  logic [7:0]  hold_q;
  logic        held_q;
  logic        over;

  // any phase above threshold, combinational so the block is instantaneous
  assign over = (ratio_a_i > threshold_i) || (ratio_b_i > threshold_i) ||
                (ratio_c_i > threshold_i);

  // hold timer counts 10 ms steps after the ratio falls
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i || over) begin
      step_q <= '0;
      hold_q <= '0;
      held_q <= !rst_i && enable_i && over; // no hold carried out of reset
    end else if (held_q) begin
      if (hold_q >= treset_i) begin
        held_q <= 1'b0;
      end else if (step_q == 32'(STEP_CYCLES - 1)) begin
        step_q <= '0;
        hold_q <= hold_q + 8'h01;
      end else begin
        step_q <= step_q + 32'h1;
      end
    end
  end

  assign inrush_o = enable_i && (over || (held_q && hold_q < treset_i));
endmodule

// *** hdl/tlb_sync.sv ***
// two flop synchroniser for a vector of pin levels
module tlb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// *** hdl/tlb_top.sv ***
// trip latch, logic blocking and inrush blocking with a wishbone slave
// Overview of operation
// - each delayed function has its own latch enable
// - latched trip holds until explicit reset
// - unlatched trip follows its command only
// - full variant resets from panel, input, remote
// - latch alarm shown only for trip relay
// - basic variant: no alarm, key-pair acknowledge resets
// - basic variant: input or remote also resets
// - each delayed threshold may be logic blocked
// - blocking holds while block input is high
// - full variant has two blocking groups
// - inrush flag instant when any phase exceeds
// - inrush disabled never raises the flag
// - ratio threshold 10 to 35 percent, 0.1 steps
// - each instantaneous threshold opts into inrush block
// - inrush flag held for 0-2 s reset delay
module tlb_top
  import tlb_pkg::*;
#(
  parameter int ND          = TLB_NUM_DELAYED,
  parameter int NI          = TLB_NUM_INST,
  parameter int STEP_CYCLES = TLB_STEP_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        wb_err_o,
  // protection function outputs, same clock
  input  wire logic [ND-1:0]          delayed_i,
  input  wire logic [NI-1:0]          inst_i,
  input  wire logic [TLB_RATIO_W-1:0] ratio_a_i,
  input  wire logic [TLB_RATIO_W-1:0] ratio_b_i,
  input  wire logic [TLB_RATIO_W-1:0] ratio_c_i,
  // logic input pins and panel keys, asynchronous
  input  wire logic                   block1_pin_i,
  input  wire logic                   block2_pin_i,
  input  wire logic                   reset_pin_i,
  input  wire logic                   panel_reset_i,
  input  wire logic                   remote_reset_i,
  // results
  output logic [ND-1:0]               delayed_blocked_o,
  output logic [NI-1:0]               inst_blocked_o,
  output logic                        trip_output_relay_o,
  output logic                        latch_alarm_o,
  output logic                        inrush_block_o,
  output logic                        irq_o
);
  // settings registers
  logic [2:0]             ctrl_q;
  logic [ND-1:0]          latch_en_q;
  logic [ND-1:0]          blk1_en_q;
  logic [ND-1:0]          blk2_en_q;
  logic [NI-1:0]          inr_en_q;
  logic [TLB_RATIO_W-1:0] ratio_q;
  logic [7:0]             treset_q;
  logic [TLB_IRQ_W-1:0]   irq_stat_q;
  logic [TLB_IRQ_W-1:0]   irq_mask_q;
  // internal state
  logic                   latch_q;
  logic                   any_blocked_q;
  logic                   inrush_q;
  logic [4:0]             pins_s;
  logic                   rst_pin_q;
  logic                   panel_q;
  logic                   remote_q;
  logic                   inrush;
  logic                   basic;
  logic                   reset_req;
  logic [ND-1:0]          cmd_active;
  logic                   unlatched_trip;
  logic                   latch_set;
  logic                   latch_clr;
  logic [TLB_IRQ_W-1:0]   irq_ev;
  logic                   wr_stb;
  logic                   rd_stb;
  logic                   hit;

  // clip a written threshold into the legal band
  function automatic logic [TLB_RATIO_W-1:0] clip_ratio(input logic [31:0] v);
    logic [TLB_RATIO_W-1:0] r;
    r = v[TLB_RATIO_W-1:0];
    if (v[31:TLB_RATIO_W] != '0 || r > TLB_RATIO_MAX) begin
      r = TLB_RATIO_MAX;
    end else if (r < TLB_RATIO_MIN) begin
      r = TLB_RATIO_MIN;
    end
    return r;
  endfunction

  // decode used by both the read and the write path
  function automatic logic is_mapped(input logic [7:0] a);
    return a == TLB_A_CTRL || a == TLB_A_LATCH_EN || a == TLB_A_BLK1_EN ||
           a == TLB_A_BLK2_EN || a == TLB_A_INR_EN || a == TLB_A_RATIO ||
           a == TLB_A_TRESET || a == TLB_A_STATUS || a == TLB_A_IRQ_STAT ||
           a == TLB_A_IRQ_MASK;
  endfunction

  // all pin levels are resynchronised before use
  tlb_sync #(
    .W (5)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({remote_reset_i, panel_reset_i, reset_pin_i, block2_pin_i, block1_pin_i}),
    .q_o   (pins_s)
  );

  tlb_inrush #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_inrush (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .enable_i    (ctrl_q[TLB_CTRL_INR_ON]),
    .threshold_i (ratio_q),
    .treset_i    (treset_q),
    .ratio_a_i   (ratio_a_i),
    .ratio_b_i   (ratio_b_i),
    .ratio_c_i   (ratio_c_i),
    .inrush_o    (inrush)
  );

  assign basic = ctrl_q[TLB_CTRL_BASIC];

  // bus strobes; single cycle ack, dropped after one cycle
  assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_we_i;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !wb_we_i;
  assign hit    = is_mapped(wb_adr_i);

  // level sensitive blocking, second group only on the full variant
  always_comb begin
    for (int i = 0; i < ND; i++) begin
      cmd_active[i] = delayed_i[i] &&
                      !(blk1_en_q[i] && pins_s[0]) &&
                      !(!basic && blk2_en_q[i] && pins_s[1]);
    end
  end

  // inrush suppresses only the opted-in instantaneous stages
  always_comb begin
    for (int i = 0; i < NI; i++) begin
      inst_blocked_o[i] = inst_i[i] && !(inr_en_q[i] && inrush);
    end
  end

  assign delayed_blocked_o = cmd_active;

  // reset sources; panel key means alarm reset or key-pair acknowledge
  assign reset_req = rst_pin_q || remote_q || panel_q ||
                     (wr_stb && hit && wb_adr_i == TLB_A_CTRL && wb_sel_i[0] &&
                      wb_dat_i[TLB_CTRL_RESET]);

  assign unlatched_trip = |(cmd_active & ~latch_en_q);
  assign latch_set      = |(cmd_active & latch_en_q);
  assign latch_clr      = reset_req && !latch_set;

  // reset levels registered once more from synchronised pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pin_q <= 1'b0;
      panel_q   <= 1'b0;
      remote_q  <= 1'b0;
    end else begin
      rst_pin_q <= pins_s[2];
      panel_q   <= pins_s[3];
      remote_q  <= pins_s[4];
    end
  end

  // single latch state; an active function wins over a reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= 1'b0;
    end else if (latch_set) begin
      latch_q <= 1'b1;
    end else if (latch_clr) begin
      latch_q <= 1'b0;
    end
  end

  // output relay and alarm; basic variant shows no alarm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_output_relay_o <= 1'b0;
      latch_alarm_o       <= 1'b0;
      inrush_block_o      <= 1'b0;
    end else begin
      trip_output_relay_o <= unlatched_trip || latch_set || (latch_q && !latch_clr);
      latch_alarm_o       <= !basic && (latch_set || (latch_q && !latch_clr));
      inrush_block_o      <= inrush;
    end
  end

  // edge history for interrupt events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      any_blocked_q <= 1'b0;
      inrush_q      <= 1'b0;
    end else begin
      any_blocked_q <= |(delayed_i & ~cmd_active);
      inrush_q      <= inrush;
    end
  end

  always_comb begin
    irq_ev                  = '0;
    irq_ev[TLB_IRQ_LATCH]   = latch_set && !latch_q;
    irq_ev[TLB_IRQ_INRUSH]  = inrush && !inrush_q;
    irq_ev[TLB_IRQ_BLOCK]   = |(delayed_i & ~cmd_active) && !any_blocked_q;
    irq_ev[TLB_IRQ_CLEARED] = latch_q && latch_clr;
  end

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (wr_stb && wb_adr_i == TLB_A_IRQ_STAT && wb_sel_i[0]) begin
      irq_stat_q <= (irq_stat_q & ~wb_dat_i[TLB_IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // settings writes; taken only when all four byte lanes are selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= 3'h0;
      latch_en_q <= '0;
      blk1_en_q  <= '0;
      blk2_en_q  <= '0;
      inr_en_q   <= '0;
      ratio_q    <= TLB_RATIO_DEF;
      treset_q   <= 8'h00;
      irq_mask_q <= '0;
    end else if (wr_stb && wb_sel_i == 4'hF) begin
      unique case (wb_adr_i)
        TLB_A_CTRL: begin
          ctrl_q <= {1'b0, wb_dat_i[TLB_CTRL_INR_ON], wb_dat_i[TLB_CTRL_BASIC]};
        end
        TLB_A_LATCH_EN: begin
          latch_en_q <= wb_dat_i[ND-1:0];
        end
        TLB_A_BLK1_EN: begin
          blk1_en_q <= wb_dat_i[ND-1:0];
        end
        TLB_A_BLK2_EN: begin
          blk2_en_q <= wb_dat_i[ND-1:0];
        end
        TLB_A_INR_EN: begin
          inr_en_q <= wb_dat_i[NI-1:0];
        end
        TLB_A_RATIO: begin
          ratio_q <= clip_ratio(wb_dat_i);
        end
        TLB_A_TRESET: begin
          treset_q <= (wb_dat_i[7:0] > TLB_TRESET_MAX) ? TLB_TRESET_MAX : wb_dat_i[7:0];
        end
        TLB_A_IRQ_MASK: begin
          irq_mask_q <= wb_dat_i[TLB_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        TLB_A_CTRL:     wb_dat_o[1:0] <= ctrl_q[1:0];
        TLB_A_LATCH_EN: wb_dat_o[ND-1:0] <= latch_en_q;
        TLB_A_BLK1_EN:  wb_dat_o[ND-1:0] <= blk1_en_q;
        TLB_A_BLK2_EN:  wb_dat_o[ND-1:0] <= blk2_en_q;
        TLB_A_INR_EN:   wb_dat_o[NI-1:0] <= inr_en_q;
        TLB_A_RATIO:    wb_dat_o[TLB_RATIO_W-1:0] <= ratio_q;
        TLB_A_TRESET:   wb_dat_o[7:0] <= treset_q;
        TLB_A_STATUS: begin
          wb_dat_o[TLB_ST_LATCHED] <= latch_q;
          wb_dat_o[TLB_ST_ALARM]   <= latch_alarm_o;
          wb_dat_o[TLB_ST_INRUSH]  <= inrush_block_o;
          wb_dat_o[TLB_ST_TRIP]    <= trip_output_relay_o;
        end
        TLB_A_IRQ_STAT: wb_dat_o[TLB_IRQ_W-1:0] <= irq_stat_q;
        TLB_A_IRQ_MASK: wb_dat_o[TLB_IRQ_W-1:0] <= irq_mask_q;
        default: begin
        end
      endcase
    end
  end

  // ack for mapped, err for unmapped, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= (wr_stb || rd_stb) && hit;
      wb_err_o <= (wr_stb || rd_stb) && !hit;
    end
  end
endmodule

// *** inc/tlb_pkg.sv ***
// shared constants for the trip latch and blocking logic
package tlb_pkg;
  // function counts
  localparam int TLB_NUM_DELAYED  = 20;
  localparam int TLB_NUM_INST     = 10;
  localparam int TLB_NUM_PHASES   = 3;
  localparam int TLB_RATIO_W      = 10;
  // second harmonic ratio in units of 0.1 percent
  localparam logic [9:0] TLB_RATIO_MIN = 10'h064;
  localparam logic [9:0] TLB_RATIO_MAX = 10'h15E;
  localparam logic [9:0] TLB_RATIO_DEF = 10'h0C8;
  // inrush reset delay in 10 ms steps, 0 to 2 s
  localparam int TLB_CLK_HZ       = 200_000_000;
  localparam int TLB_STEP_MS      = 10;
  localparam int TLB_STEP_CYCLES  = TLB_CLK_HZ / 1000 * TLB_STEP_MS;
  localparam logic [7:0] TLB_TRESET_MAX = 8'hC8;
  // wishbone register byte addresses
  localparam logic [7:0] TLB_A_CTRL     = 8'h00;
  localparam logic [7:0] TLB_A_LATCH_EN = 8'h04;
  localparam logic [7:0] TLB_A_BLK1_EN  = 8'h08;
  localparam logic [7:0] TLB_A_BLK2_EN  = 8'h0C;
  localparam logic [7:0] TLB_A_INR_EN   = 8'h10;
  localparam logic [7:0] TLB_A_RATIO    = 8'h14;
  localparam logic [7:0] TLB_A_TRESET   = 8'h18;
  localparam logic [7:0] TLB_A_STATUS   = 8'h1C;
  localparam logic [7:0] TLB_A_IRQ_STAT = 8'h20;
  localparam logic [7:0] TLB_A_IRQ_MASK = 8'h24;
  // control register fields
  localparam int TLB_CTRL_BASIC   = 0;
  localparam int TLB_CTRL_INR_ON  = 1;
  localparam int TLB_CTRL_RESET   = 2;
  // status and interrupt fields
  localparam int TLB_ST_LATCHED   = 0;
  localparam int TLB_ST_ALARM     = 1;
  localparam int TLB_ST_INRUSH    = 2;
  localparam int TLB_ST_TRIP      = 3;
  localparam int TLB_IRQ_W        = 4;
  localparam int TLB_IRQ_LATCH    = 0;
  localparam int TLB_IRQ_INRUSH   = 1;
  localparam int TLB_IRQ_BLOCK    = 2;
  localparam int TLB_IRQ_CLEARED  = 3;
endpackage

// *** sim/testbench.sv ***
// self-checking bench for the trip latch and blocking block
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module testbench
  import tlb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, lfsr_q;
  logic [19:0] delayed_i, delayed_blocked_o, dly_cmd, m1, m2;
  logic [9:0]  inst_i, inst_blocked_o, inst_cmd, mi, h2, ratio_a_i, ratio_b_i, ratio_c_i;
  logic [1:0]  h2_ph;
  logic        block1_pin_i, block2_pin_i, reset_pin_i, panel_reset_i, remote_reset_i;
  logic        trip_output_relay_o, latch_alarm_o, inrush_block_o, irq_o, er, slow, basic;
  int          err_total, checks, k;

  tlb_top #(.STEP_CYCLES(SC)) u_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .delayed_i, .inst_i, .ratio_a_i, .ratio_b_i,
    .ratio_c_i, .block1_pin_i, .block2_pin_i, .reset_pin_i, .panel_reset_i,
    .remote_reset_i, .delayed_blocked_o, .inst_blocked_o, .trip_output_relay_o,
    .latch_alarm_o, .inrush_block_o, .irq_o
  );
  tlb_fn_model u_fn (
    .clk_i, .slow_i(slow), .dly_cmd_i(dly_cmd), .inst_cmd_i(inst_cmd), .h2_i(h2),
    .phase_i(h2_ph), .delayed_o(delayed_i), .inst_o(inst_i), .ratio_a_o(ratio_a_i),
    .ratio_b_o(ratio_b_i), .ratio_c_o(ratio_c_i)
  );

  task automatic end_of_test();
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  // expected value of a setting that clips at its limits
  function automatic logic [9:0] clip(logic [9:0] v, logic [9:0] lo, logic [9:0] hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction
  // expected outputs when an active block removes the masked functions
  function automatic logic [19:0] keep(logic [19:0] d, logic [19:0] m, logic on);
    return on ? d & ~m : d;
  endfunction
  // one classic cycle; the bound only guards against a hang
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 16) begin
      err_total++;
      end_of_test();
    end
    step(1);
  endtask
  // reset source: 0 remote write, 1 logic input, 2 panel key, 3 remote line
  task automatic clr(input int s);
    if (s == 0) wb(1'b1, TLB_A_CTRL, {29'h0, 2'h2, basic});
    else begin
      {remote_reset_i, panel_reset_i, reset_pin_i} <= 3'h1 << (s - 1);
      step(6);
      {remote_reset_i, panel_reset_i, reset_pin_i} <= 3'h0;
    end
    step(6);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // watchdog for the whole run
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {block1_pin_i, block2_pin_i, reset_pin_i, panel_reset_i, remote_reset_i} = '0;
    {dly_cmd, inst_cmd, h2, h2_ph, slow, basic} = '0;
    err_total = 0;
    checks = 0;
    lfsr_q = 32'h0001_3347;
    rst_i = 1'b1;
    step(2);
    rst_i <= 1'b0;
    step(1);
    // defaults, then an unmapped address
    wb(1'b0, TLB_A_RATIO, 32'h0);
    `CHK("ratio_default", TLB_RATIO_DEF, rd[9:0])
    wb(1'b0, 8'h80, 32'h0);
    `CHK("unmapped_err", 1'b1, er)
    // limits of both settings, then random values
    // setting values kept in a bench variable; the harmonic input stays at zero
    for (int i = 0; i < 4; i++) begin
      mi = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'(rnd());
      wb(1'b1, TLB_A_RATIO, {22'h0, mi});
      wb(1'b0, TLB_A_RATIO, 32'h0);
      `CHK("ratio_clip", clip(mi, TLB_RATIO_MIN, TLB_RATIO_MAX), rd[9:0])
      wb(1'b1, TLB_A_TRESET, {24'h0, mi[7:0]});
      wb(1'b0, TLB_A_TRESET, 32'h0);
      `CHK("treset_clip", clip({2'h0, mi[7:0]}, 10'h0, {2'h0, TLB_TRESET_MAX}),
        {2'h0, rd[7:0]})
    end
    // latch of one random function per pass in both variants with every reset source
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 4; s++) begin
        basic = b[0];
        k = int'(rnd() % 32'd20);
        wb(1'b1, TLB_A_CTRL, {31'h0, basic});
        wb(1'b1, TLB_A_LATCH_EN, 32'h1 << k);
        wb(1'b1, TLB_A_IRQ_MASK, 32'h1);
        dly_cmd <= 20'h1 << ((k + 1) % 20);
        step(3);
        `CHK("trip_unlatched_on", 1'b1, trip_output_relay_o)
        dly_cmd <= '0;
        step(3);
        `CHK("trip_unlatched_off", 1'b0, trip_output_relay_o)
        dly_cmd <= 20'h1 << k;
        step(3);
        clr(s);
        dly_cmd <= '0;
        step(3);
        `CHK("trip_latched", 1'b1, trip_output_relay_o)
        `CHK("latch_alarm", !basic, latch_alarm_o)
        wb(1'b0, TLB_A_STATUS, 32'h0);
        `CHK("status_latched", {28'h0, 1'b1, 1'b0, ~basic, 1'b1}, rd)
        `CHK("irq_raised", 1'b1, irq_o)
        wb(1'b1, TLB_A_IRQ_MASK, 32'h0);
        `CHK("irq_masked", 1'b0, irq_o)
        clr(s);
        `CHK("trip_cleared", 1'b0, trip_output_relay_o)
        wb(1'b0, TLB_A_IRQ_STAT, 32'h0);
        `CHK("irq_stat", 32'h9, rd)
        wb(1'b1, TLB_A_IRQ_STAT, 32'hF);
        wb(1'b1, TLB_A_IRQ_MASK, 32'hF);
        `CHK("irq_cleared", 1'b0, irq_o)
      end
    end
    wb(1'b1, TLB_A_LATCH_EN, 32'h0);
    // random block masks, pins and commands, prompt and slow detectors
    for (int i = 0; i < 12; i++) begin
      basic = 1'(rnd());
      m1 = 20'(rnd());
      m2 = 20'(rnd());
      wb(1'b1, TLB_A_CTRL, {31'h0, basic});
      wb(1'b1, TLB_A_BLK1_EN, {12'h0, m1});
      wb(1'b1, TLB_A_BLK2_EN, {12'h0, m2});
      {slow, block2_pin_i, block1_pin_i} <= 3'(rnd());
      dly_cmd <= 20'(rnd());
      step(6);
      `CHK("blocked", keep(keep(dly_cmd, m1, block1_pin_i), m2, block2_pin_i & !basic),
        delayed_blocked_o)
    end
    {dly_cmd, slow, block2_pin_i, block1_pin_i} <= '0;
    // inrush on each phase, enabled and disabled, with a two-step hold
    wb(1'b1, TLB_A_RATIO, 32'h0C8);
    wb(1'b1, TLB_A_TRESET, 32'h2);
    mi = 10'(rnd());
    wb(1'b1, TLB_A_INR_EN, {22'h0, mi});
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, TLB_A_CTRL, {30'h0, e[0], 1'b0});
      for (int p = 0; p < 3; p++) begin
        inst_cmd <= 10'(rnd());
        h2_ph <= 2'(p);
        h2 <= TLB_RATIO_DEF + 10'h1;
        step(3);
        `CHK("inrush_on", e[0], inrush_block_o)
        `CHK("inst", 10'(keep({10'h0, inst_cmd}, {10'h0, mi}, e[0])), inst_blocked_o)
        h2 <= TLB_RATIO_DEF;
        step(4);
        `CHK("inrush_hold", e[0], inrush_block_o)
        step(12);
        `CHK("inrush_off", 1'b0, inrush_block_o)
      end
    end
    // reset again in mid-run
    rst_i <= 1'b1;
    step(2);
    rst_i <= 1'b0;
    step(1);
    wb(1'b0, TLB_A_CTRL, 32'h0);
    `CHK("ctrl_after_reset", 32'h0, rd)
    end_of_test();
  end
endmodule

// *** sim/tlb_checker.sv ***
// concurrent checks on the trip latch and blocking block ports
module tlb_checker
  import tlb_pkg::*;
#(
  parameter int ND          = TLB_NUM_DELAYED,
  parameter int NI          = TLB_NUM_INST,
  parameter int STEP_CYCLES = TLB_STEP_CYCLES
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic                   wb_ack_o,
  input wire logic                   wb_err_o,
  input wire logic [ND-1:0]          delayed_i,
  input wire logic [NI-1:0]          inst_i,
  input wire logic [TLB_RATIO_W-1:0] ratio_a_i,
  input wire logic [TLB_RATIO_W-1:0] ratio_b_i,
  input wire logic [TLB_RATIO_W-1:0] ratio_c_i,
  input wire logic                   block1_pin_i,
  input wire logic                   block2_pin_i,
  input wire logic [ND-1:0]          delayed_blocked_o,
  input wire logic [NI-1:0]          inst_blocked_o,
  input wire logic                   trip_output_relay_o,
  input wire logic                   latch_alarm_o,
  input wire logic                   inrush_block_o,
  input wire logic                   irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a bus request that the slave has not answered yet
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  a_bus_answer: assert property (req |=> wb_ack_o ^ wb_err_o)
    else $error("bus request not answered one cycle later");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_unmapped_err: assert property (req && wb_adr_i > TLB_A_IRQ_MASK |=> wb_err_o)
    else $error("unmapped address not refused");
  a_trip_follow: assert property (|delayed_blocked_o |=> trip_output_relay_o)
    else $error("trip relay missed an active command");
  a_trip_release: assert property ($fell(trip_output_relay_o) |-> !$past(|delayed_blocked_o))
    else $error("trip relay dropped while a command was active");
  a_trip_cause: assert property ($rose(trip_output_relay_o) |-> $past(|delayed_blocked_o))
    else $error("trip relay rose without a command");
  a_block_idle: assert property ((!block1_pin_i && !block2_pin_i) [*3]
    |-> delayed_blocked_o == delayed_i)
    else $error("delayed output suppressed with no blocking input");
  a_inst_subset: assert property ((inst_blocked_o & ~inst_i) == '0)
    else $error("instantaneous output without a pickup");
  a_inst_cause: assert property (inst_blocked_o != inst_i |=> inrush_block_o)
    else $error("instantaneous stage suppressed without inrush");
  a_alarm_trip: assert property ($rose(latch_alarm_o) |-> trip_output_relay_o)
    else $error("latch alarm without trip relay");
  a_inrush_cause: assert property ($rose(inrush_block_o) |-> $past(ratio_a_i > TLB_RATIO_MIN
    || ratio_b_i > TLB_RATIO_MIN || ratio_c_i > TLB_RATIO_MIN))
    else $error("inrush flag without a high harmonic ratio");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=> !trip_output_relay_o
    && !latch_alarm_o && !inrush_block_o && !irq_o)
    else $error("outputs not cleared by reset");
  // main scenarios reached
  c_alarm: cover property ($rose(latch_alarm_o));
  c_inrush: cover property ($rose(inrush_block_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind tlb_top tlb_checker #(.ND(ND), .NI(NI), .STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_ack_o, .wb_err_o, .delayed_i,
  .inst_i, .ratio_a_i, .ratio_b_i, .ratio_c_i, .block1_pin_i, .block2_pin_i,
  .delayed_blocked_o, .inst_blocked_o, .trip_output_relay_o, .latch_alarm_o,
  .inrush_block_o, .irq_o
);

// *** sim/tlb_fn_model.sv ***
// model of the protection detectors that feed the block
module tlb_fn_model
  import tlb_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   slow_i,
  input  wire logic [19:0]            dly_cmd_i,
  input  wire logic [9:0]             inst_cmd_i,
  input  wire logic [TLB_RATIO_W-1:0] h2_i,
  input  wire logic [1:0]             phase_i,
  output logic      [19:0]            delayed_o,
  output logic      [9:0]             inst_o,
  output logic      [TLB_RATIO_W-1:0] ratio_a_o,
  output logic      [TLB_RATIO_W-1:0] ratio_b_o,
  output logic      [TLB_RATIO_W-1:0] ratio_c_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] dly_q;
  logic [9:0]  inst_q;
  // slow detectors lag one edge behind the command
  always_ff @(posedge clk_i) begin
    dly_q  <= dly_cmd_i;
    inst_q <= inst_cmd_i;
  end
  assign delayed_o = slow_i ? dly_q : dly_cmd_i;
  assign inst_o    = slow_i ? inst_q : inst_cmd_i;
  // harmonic ratio on one phase, the others quiet
  assign ratio_a_o = (phase_i == 2'h0) ? h2_i : '0;
  assign ratio_b_o = (phase_i == 2'h1) ? h2_i : '0;
  assign ratio_c_o = (phase_i == 2'h2) ? h2_i : '0;
endmodule
